// File: src/arf_consts.vh
`ifndef ARF_CONSTS_VH
`define ARF_CONSTS_VH

// Register byte offsets
`define ARF_OFS_CTX_CTL 8'h00
`define ARF_OFS_CONFIG 8'h04
`define ARF_OFS_STATUS 8'h08
`define ARF_OFS_LAST_TRAILER 8'h0c

// Reset values
`define ARF_CTX_CTL_RST 16'h0000
`define ARF_CONFIG_RST 1'b0

// Config field position
`define ARF_CFG_NO_MASTER_BIT 0

// AXI responses
`define ARF_RESP_OKAY 2'b00
`define ARF_RESP_SLVERR 2'b10

// Header word fields: tcode in first word, byte count in fourth word
`define ARF_TCODE_HI 7
`define ARF_TCODE_LO 4
`define ARF_LEN_HI 31
`define ARF_LEN_LO 16

// Transaction codes
`define ARF_TC_WR_QUAD 4'h0
`define ARF_TC_WR_BLOCK 4'h1
`define ARF_TC_WR_RESP 4'h2
`define ARF_TC_RD_QUAD 4'h4
`define ARF_TC_RD_BLOCK 4'h5
`define ARF_TC_RD_QUAD_RESP 4'h6
`define ARF_TC_RD_BLOCK_RESP 4'h7
`define ARF_TC_LOCK_REQ 4'h9
`define ARF_TC_LOCK_RESP 4'hb

// Synthesized PHY record header
`define ARF_PHY_HEADER 32'h000000e0

// Header quadlet counts
`define ARF_HDR_SHORT 3'd3
`define ARF_HDR_LONG 3'd4

`endif

// File: src/arf_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "arf_consts.vh"

module arf_regs (
   input wire core_clk,
   input wire rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] status_in,
   input wire [31:0] last_trailer_in,
   output reg [15:0] ctx_ctl_q,
   output reg no_master_q
);

   reg aw_have_q;
   reg w_have_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire do_write;

   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ARF_RESP_OKAY;
         ctx_ctl_q <= `ARF_CTX_CTL_RST;
         no_master_q <= `ARF_CONFIG_RST;
      end else begin
         // Address and data taken in either order
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ARF_RESP_OKAY;
            case (aw_addr_q)
               `ARF_OFS_CTX_CTL: begin
                  if (w_strb_q[0]) begin
                     ctx_ctl_q[7:0] <= w_data_q[7:0];
                  end
                  if (w_strb_q[1]) begin
                     ctx_ctl_q[15:8] <= w_data_q[15:8];
                  end
               end
               `ARF_OFS_CONFIG: begin
                  if (w_strb_q[0]) begin
                     no_master_q <= w_data_q[`ARF_CFG_NO_MASTER_BIT];
                  end
               end
               `ARF_OFS_STATUS, `ARF_OFS_LAST_TRAILER: begin
                  s_axi_bresp <= `ARF_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `ARF_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ARF_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ARF_RESP_OKAY;
            case (s_axi_araddr)
               `ARF_OFS_CTX_CTL: s_axi_rdata <= {16'h0000, ctx_ctl_q};
               `ARF_OFS_CONFIG: s_axi_rdata <= {31'h00000000, no_master_q};
               `ARF_OFS_STATUS: s_axi_rdata <= status_in;
               `ARF_OFS_LAST_TRAILER: s_axi_rdata <= last_trailer_in;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `ARF_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: src/arf_framer.v
// Contract
// - Sort each packet into no-data, quadlet or block layout by transaction code, or PHY layout by PHY flag; other codes are dropped.
// - Keep destination identifier as bus number then node number, unchanged.
// - Keep the two-bit retry code exactly as received.
// - Copy reserved header bits unchecked and unmodified.
// - Keep the six-bit transaction label in the record.
// - Requests store sender id with upper offset, then full lower offset word.
// - First payload byte lands in most significant byte of first payload word.
// - Zero payload byte count writes no payload words.
// - Sender pads to whole quadlets; device stores the whole final quadlet.
// - Trailer transfer status comes from context control register low half.
// - Cycle stamp is seconds low three bits with thirteen-bit cycle count.
// - Without cycle master, stamp comes from the local cycle timer.
// - Quadlet read request record is three header words plus trailer.
// - Write response record: sender id and response code, reserved word, trailer.
// - Quadlet write request places data quadlet in fourth word.
// - Quadlet read response: response code, reserved word, data quadlet, trailer.
// - Block read request keeps byte count in fourth word, no payload.
// - Block records hold byte count and extended code, payload, then trailer.
// - Lock records keep the extended code identifying the lock operation.
// - Response records keep response code beside sender identifier.
// - Every record ends with status upper half and cycle stamp lower half.
// - PHY record: synthesized header, PHY quadlet, its inverse, trailer.
// - Errored packets are abandoned and never completed for software.
`timescale 1ns/100ps
`default_nettype none
`include "arf_consts.vh"

module arf_framer (
   input wire core_clk,
   input wire rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire lnk_valid,
   output reg lnk_ready,
   input wire [31:0] lnk_data,
   input wire lnk_last,
   input wire lnk_err,
   input wire lnk_phy,
   input wire cs_strobe,
   input wire [2:0] cs_seconds,
   input wire [12:0] cs_count,
   input wire [2:0] ct_seconds,
   input wire [12:0] ct_count,
   output reg rec_valid,
   input wire rec_ready,
   output reg [31:0] rec_data,
   output reg rec_end,
   output reg rec_drop
);

   localparam [2:0] ST_HDR = 3'd0;
   localparam [2:0] ST_DATA = 3'd1;
   localparam [2:0] ST_DCRC = 3'd2;
   localparam [2:0] ST_PHY_Q = 3'd3;
   localparam [2:0] ST_PHY_INV = 3'd4;
   localparam [2:0] ST_PHY_WAIT = 3'd5;
   localparam [2:0] ST_TRAIL = 3'd6;
   localparam [2:0] ST_SKIP = 3'd7;

   wire [15:0] ctx_ctl;
   wire no_master;
   reg [2:0] st_q;
   reg [2:0] st_d;
   reg [2:0] hidx_q;
   reg [2:0] hidx_d;
   reg [2:0] hnum_q;
   reg [2:0] hnum_d;
   reg blk_q;
   reg blk_d;
   reg err_q;
   reg err_d;
   reg [14:0] dcnt_q;
   reg [14:0] dcnt_d;
   reg [31:0] phy_q;
   reg [31:0] phy_d;
   reg [31:0] out_data_d;
   reg out_valid_d;
   reg out_end_d;
   reg drop_d;
   reg [15:0] cs_stamp_q;
   reg [15:0] good_cnt_q;
   reg [15:0] drop_cnt_q;
   reg [31:0] last_trl_q;
   reg [15:0] stamp;
   reg [16:0] len_round;
   reg bad;
   wire free;
   wire beat;
   wire wants_input;

   assign free = !rec_valid || rec_ready;
   assign beat = lnk_valid && lnk_ready;
   assign wants_input = (st_d == ST_HDR) || (st_d == ST_DATA) || (st_d == ST_DCRC) ||
                        (st_d == ST_PHY_WAIT) || (st_d == ST_SKIP);

   arf_regs u_regs (
      .core_clk(core_clk),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .status_in({drop_cnt_q, good_cnt_q}),
      .last_trailer_in(last_trl_q),
      .ctx_ctl_q(ctx_ctl),
      .no_master_q(no_master)
   );

   always @* begin
      if (no_master) begin
         stamp = {ct_seconds, ct_count};
      end else begin
         stamp = cs_stamp_q;
      end
      st_d = st_q;
      hidx_d = hidx_q;
      hnum_d = hnum_q;
      blk_d = blk_q;
      err_d = err_q | (beat & lnk_err);
      dcnt_d = dcnt_q;
      phy_d = phy_q;
      out_valid_d = rec_valid & !rec_ready;
      out_data_d = rec_data;
      out_end_d = rec_end & !rec_ready;
      drop_d = 1'b0;
      bad = err_q | lnk_err;
      len_round = {1'b0, lnk_data[`ARF_LEN_HI:`ARF_LEN_LO]} + 17'h00003;
      case (st_q)
         ST_HDR: begin
            if (beat) begin
               if (hidx_q == 3'd0) begin
                  err_d = lnk_err;
                  hidx_d = 3'd1;
                  if (lnk_phy) begin
                     phy_d = lnk_data;
                     out_valid_d = 1'b1;
                     out_data_d = `ARF_PHY_HEADER;
                     hidx_d = 3'd0;
                     st_d = ST_PHY_Q;
                  end else begin
                     case (lnk_data[`ARF_TCODE_HI:`ARF_TCODE_LO])
                        `ARF_TC_RD_QUAD, `ARF_TC_WR_RESP: begin
                           hnum_d = `ARF_HDR_SHORT;
                           blk_d = 1'b0;
                        end
                        `ARF_TC_WR_QUAD, `ARF_TC_RD_QUAD_RESP, `ARF_TC_RD_BLOCK: begin
                           hnum_d = `ARF_HDR_LONG;
                           blk_d = 1'b0;
                        end
                        `ARF_TC_WR_BLOCK, `ARF_TC_RD_BLOCK_RESP, `ARF_TC_LOCK_REQ, `ARF_TC_LOCK_RESP: begin
                           hnum_d = `ARF_HDR_LONG;
                           blk_d = 1'b1;
                        end
                        default: begin
                           hnum_d = 3'd0;
                           hidx_d = 3'd0;
                        end
                     endcase
                     if (hnum_d == 3'd0) begin
                        st_d = ST_SKIP;
                     end else begin
                        out_valid_d = 1'b1;
                        out_data_d = lnk_data;
                     end
                  end
                  if (lnk_last) begin
                     st_d = ST_HDR;
                     hidx_d = 3'd0;
                     drop_d = 1'b1;
                  end
               end else if (hidx_q < hnum_q) begin
                  out_valid_d = 1'b1;
                  out_data_d = lnk_data;
                  hidx_d = hidx_q + 3'd1;
                  if (blk_q && hidx_q == 3'd3) begin
                     dcnt_d = len_round[16:2];
                  end
                  if (lnk_last) begin
                     st_d = ST_HDR;
                     hidx_d = 3'd0;
                     drop_d = 1'b1;
                  end
               end else begin
                  hidx_d = 3'd0;
                  if (blk_q && dcnt_q != 15'd0) begin
                     if (lnk_last) begin
                        drop_d = 1'b1;
                     end else begin
                        st_d = ST_DATA;
                     end
                  end else if (!lnk_last) begin
                     st_d = ST_SKIP;
                  end else if (bad) begin
                     drop_d = 1'b1;
                  end else begin
                     st_d = ST_TRAIL;
                  end
               end
            end
         end
         ST_DATA: begin
            if (beat) begin
               out_valid_d = 1'b1;
               out_data_d = lnk_data;
               dcnt_d = dcnt_q - 15'd1;
               if (lnk_last) begin
                  st_d = ST_HDR;
                  drop_d = 1'b1;
               end else if (dcnt_q == 15'd1) begin
                  st_d = ST_DCRC;
               end
            end
         end
         ST_DCRC, ST_PHY_WAIT: begin
            if (beat) begin
               if (!lnk_last) begin
                  st_d = ST_SKIP;
               end else if (bad) begin
                  st_d = ST_HDR;
                  drop_d = 1'b1;
               end else begin
                  st_d = ST_TRAIL;
               end
            end
         end
         ST_PHY_Q: begin
            if (free) begin
               out_valid_d = 1'b1;
               out_data_d = phy_q;
               st_d = ST_PHY_INV;
            end
         end
         ST_PHY_INV: begin
            if (free) begin
               out_valid_d = 1'b1;
               out_data_d = ~phy_q;
               st_d = ST_PHY_WAIT;
            end
         end
         ST_TRAIL: begin
            if (free) begin
               out_valid_d = 1'b1;
               out_data_d = {ctx_ctl, stamp};
               out_end_d = 1'b1;
               st_d = ST_HDR;
            end
         end
         ST_SKIP: begin
            if (beat && lnk_last) begin
               st_d = ST_HDR;
               drop_d = 1'b1;
            end
         end
         default: begin
            st_d = ST_HDR;
         end
      endcase
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_HDR;
         hidx_q <= 3'd0;
         hnum_q <= 3'd0;
         blk_q <= 1'b0;
         err_q <= 1'b0;
         dcnt_q <= 15'd0;
         phy_q <= 32'h00000000;
         rec_valid <= 1'b0;
         rec_data <= 32'h00000000;
         rec_end <= 1'b0;
         rec_drop <= 1'b0;
         lnk_ready <= 1'b0;
         cs_stamp_q <= 16'h0000;
         good_cnt_q <= 16'h0000;
         drop_cnt_q <= 16'h0000;
         last_trl_q <= 32'h00000000;
      end else begin
         st_q <= st_d;
         hidx_q <= hidx_d;
         hnum_q <= hnum_d;
         blk_q <= blk_d;
         err_q <= err_d;
         dcnt_q <= dcnt_d;
         phy_q <= phy_d;
         rec_valid <= out_valid_d;
         rec_data <= out_data_d;
         rec_end <= out_end_d;
         rec_drop <= drop_d;
         // Accept only when the output slot will be empty
         lnk_ready <= wants_input && !out_valid_d;
         if (cs_strobe) begin
            cs_stamp_q <= {cs_seconds, cs_count};
         end
         if (drop_d) begin
            drop_cnt_q <= drop_cnt_q + 16'h0001;
         end
         if (st_q == ST_TRAIL && free) begin
            good_cnt_q <= good_cnt_q + 16'h0001;
            last_trl_q <= out_data_d;
         end
      end
   end

endmodule

`default_nettype wire

// File: sim/arf_framer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "arf_consts.vh"
module arf_framer_asserts (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic lnk_valid,
   input wire logic lnk_ready,
   input wire logic [31:0] lnk_data,
   input wire logic lnk_last,
   input wire logic lnk_err,
   input wire logic lnk_phy,
   input wire logic cs_strobe,
   input wire logic [2:0] cs_seconds,
   input wire logic [12:0] cs_count,
   input wire logic [2:0] ct_seconds,
   input wire logic [12:0] ct_count,
   input wire logic rec_valid,
   input wire logic rec_ready,
   input wire logic [31:0] rec_data,
   input wire logic rec_end,
   input wire logic rec_drop
);
   logic in_pkt_q, bad_q;
   logic [15:0] cs_q;
   wire take = lnk_valid && lnk_ready;
   wire bad_now = lnk_err || bad_q || (!in_pkt_q && !lnk_phy && (lnk_data[7:4] inside {4'h3, 4'h8, 4'ha, [4'hc:4'hf]}));
   // Packet tracking for the checks below
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_pkt_q <= 1'b0;
         bad_q <= 1'b0;
         cs_q <= 16'h0000;
      end else begin
         if (cs_strobe) cs_q <= {cs_seconds, cs_count};
         if (take) begin
            in_pkt_q <= !lnk_last;
            bad_q <= !lnk_last && bad_now;
         end
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_last_beat;
      lnk_valid && lnk_ready && lnk_last;
   endsequence
   sequence s_trailer;
      rec_valid && rec_end;
   endsequence
   a_rec_held: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_end))
      else $error("record word changed before taken");
   a_drop_pulse: assert property (rec_drop |=> !rec_drop)
      else $error("drop longer than one cycle");
   a_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response withdrawn");
   a_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response withdrawn");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_trailer_due: assert property (s_last_beat ##0 !bad_now |-> ##[1:12] s_trailer)
      else $error("no trailer after good packet");
   a_error_drop: assert property (s_last_beat ##0 bad_now |-> ##[1:8] rec_drop)
      else $error("bad packet not dropped");
   a_error_no_end: assert property (s_last_beat ##0 bad_now |=> (!(rec_valid && rec_end)) [*4])
      else $error("bad packet committed");
   a_stamp_source: assert property (s_trailer |-> rec_data[15:0] == cs_q || rec_data[15:0] == {ct_seconds, ct_count})
      else $error("cycle stamp from wrong source");
   a_phy_header: assert property (take && lnk_phy && !in_pkt_q |-> ##[1:2] (rec_valid && rec_data == `ARF_PHY_HEADER))
      else $error("phy record header wrong");
endmodule
bind arf_framer arf_framer_asserts u_chk (.core_clk(core_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .lnk_valid(lnk_valid),
   .lnk_ready(lnk_ready), .lnk_data(lnk_data), .lnk_last(lnk_last), .lnk_err(lnk_err), .lnk_phy(lnk_phy),
   .cs_strobe(cs_strobe), .cs_seconds(cs_seconds), .cs_count(cs_count), .ct_seconds(ct_seconds),
   .ct_count(ct_count), .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .rec_end(rec_end),
   .rec_drop(rec_drop));
`default_nettype wire

// File: sim/arf_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module arf_link_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic lnk_ready,
   output logic lnk_valid = 1'b0,
   output logic [31:0] lnk_data = 32'h0,
   output logic lnk_last = 1'b0,
   output logic lnk_err = 1'b0,
   output logic lnk_phy = 1'b0
);
   logic [34:0] beats[$];
   logic gap_q = 1'b0;
   task automatic push(input logic [31:0] d, input logic last, input logic err, input logic phy);
      beats.push_back({phy, err, last, d});
   endtask
   // Beats held until taken; idle data shows the inverse of the last beat
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lnk_valid <= 1'b0;
      end else begin
         gap_q <= ~gap_q;
         if (lnk_valid && lnk_ready) begin
            lnk_valid <= 1'b0;
            lnk_data <= ~lnk_data;
            {lnk_phy, lnk_err, lnk_last} <= 3'b000;
         end else if (!lnk_valid && beats.size() > 0 && !(slow && gap_q)) begin
            {lnk_phy, lnk_err, lnk_last, lnk_data} <= beats.pop_front();
            lnk_valid <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/arf_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "arf_consts.vh"
module arf_framer_tb;
   typedef struct packed {logic [31:0] w0; logic [31:0] w3; logic [15:0] len; logic [2:0] nh; logic [3:0] nrec;} arf_row_t;
   logic core_clk = 0, rst = 1, cs_strobe = 0, slow = 0, rec_ready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, last_tr = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, lnk_data, rec_data;
   wire lnk_valid, lnk_ready, lnk_last, lnk_err, lnk_phy, rec_valid, rec_end, rec_drop;
   logic [2:0] cs_seconds = 0, ct_seconds = 3'd2;
   logic [12:0] cs_count = 0, ct_count = 13'h0123;
   logic [15:0] ctx = 16'ha5c3, stamp = {3'd5, 13'h1abc};
   int n_errors = 0, checks_done = 0, n_drops = 0, cyc = 0, n_good = 0, n_bad = 0;
   logic [32:0] got[$];
   arf_row_t rows [10] = '{
      '{32'hffc2fd4a, 32'h0, 16'd0, 3'd3, 4'd4}, '{32'hffff0525, 32'h0, 16'd0, 3'd3, 4'd4},
      '{32'h03ff8a03, 32'hcafef00d, 16'd0, 3'd4, 4'd5}, '{32'hffc10f6f, 32'h5a5aa5a5, 16'd0, 3'd4, 4'd5},
      '{32'hffc00457, 32'h00100000, 16'd0, 3'd4, 4'd5}, '{32'hffc00810, 32'h00070000, 16'd7, 3'd4, 4'd7},
      '{32'hffc00c79, 32'h00000000, 16'd0, 3'd4, 4'd5}, '{32'hffc01092, 32'h00080002, 16'd8, 3'd4, 4'd7},
      '{32'hffc014b3, 32'h00040003, 16'd4, 3'd4, 4'd6}, '{32'h87654321, 32'h0, 16'd0, 3'd0, 4'd4}};
   arf_framer u_arf_framer (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .lnk_valid(lnk_valid), .lnk_ready(lnk_ready), .lnk_data(lnk_data),
      .lnk_last(lnk_last), .lnk_err(lnk_err), .lnk_phy(lnk_phy), .cs_strobe(cs_strobe), .cs_seconds(cs_seconds),
      .cs_count(cs_count), .ct_seconds(ct_seconds), .ct_count(ct_count), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec_data(rec_data), .rec_end(rec_end), .rec_drop(rec_drop));
   arf_link_model u_arf_link_model (.core_clk(core_clk), .rst(rst), .slow(slow), .lnk_ready(lnk_ready),
      .lnk_valid(lnk_valid), .lnk_data(lnk_data), .lnk_last(lnk_last), .lnk_err(lnk_err), .lnk_phy(lnk_phy));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // Record sink stalls one cycle in four
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      rec_ready <= (cyc % 4) != 1;
      if (rec_valid && rec_ready) got.push_back({rec_end, rec_data});
      if (rec_drop) begin
         got.delete();
         n_drops <= n_drops + 1;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask
   // Sends one packet; err_at >= 0 expects a drop, beats from err_at on carry the error flag
   task automatic run(input arf_row_t r, input int err_at);
      logic [31:0] b[$], e[$];
      int nd, t, d0;
      nd = (r.len + 3) / 4;
      d0 = n_drops;
      if (r.nh == 0) begin
         b = {r.w0, ~r.w0};
         e = {`ARF_PHY_HEADER, r.w0, ~r.w0};
      end else begin
         b = {r.w0, 32'hffc1a001, 32'h12345678};
         if (r.nh == 4) b.push_back(r.w3);
         e = b;
         b.push_back(32'hc0c00001);
         // sender pads, check words follow header and data
         for (int i = 0; i < nd; i++) begin
            b.push_back(32'h01020304 + 32'(i) * 32'h04040404);
            e.push_back(32'h01020304 + 32'(i) * 32'h04040404);
         end
         if (nd > 0) b.push_back(32'hc0c00002);
      end
      e.push_back({ctx, stamp});
      foreach (b[i]) u_arf_link_model.push(b[i], i == b.size() - 1, err_at >= 0 && i >= err_at, i == 0 && r.nh == 0);
      t = 0;
      while (t < 400 && n_drops == d0 && (got.size() == 0 || got[$][32] !== 1'b1)) begin
         @(posedge core_clk);
         t++;
      end
      if (err_at >= 0) begin
         n_bad++;
         chk(32'(n_drops - d0), 32'd1);
      end else begin
         n_good++;
         last_tr = {ctx, stamp};
         chk(32'(got.size()), {28'h0, r.nrec});
         chk({31'h0, got[$][32]}, 32'h1);
         foreach (e[i]) chk(got[i][31:0], e[i]);
      end
      got.delete();
   endtask
   task automatic conclude;
      if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      conclude;
   end
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      chk({31'h0, rec_valid}, 32'h0);
      rd_chk(`ARF_OFS_CTX_CTL, 32'h0, `ARF_RESP_OKAY);
      rd_chk(`ARF_OFS_CONFIG, 32'h0, `ARF_RESP_OKAY);
      axi_wr(`ARF_OFS_CTX_CTL, {16'h0, ctx}, `ARF_RESP_OKAY);
      cs_seconds <= 3'd5;
      cs_count <= 13'h1abc;
      cs_strobe <= 1'b1;
      @(posedge core_clk);
      cs_strobe <= 1'b0;
      foreach (rows[i]) run(rows[i], -1);
      slow <= 1'b1;
      run(rows[5], -1);
      slow <= 1'b0;
      run(rows[7], 6);
      run('{32'hffc00030, 32'h0, 16'd0, 3'd3, 4'd0}, 99);
      axi_wr(`ARF_OFS_CONFIG, 32'h1, `ARF_RESP_OKAY);
      stamp = {ct_seconds, ct_count};
      run(rows[2], -1);
      rd_chk(`ARF_OFS_STATUS, {16'(n_bad), 16'(n_good)}, `ARF_RESP_OKAY);
      axi_wr(`ARF_OFS_STATUS, 32'hffffffff, `ARF_RESP_OKAY);
      rd_chk(`ARF_OFS_STATUS, {16'(n_bad), 16'(n_good)}, `ARF_RESP_OKAY);
      rd_chk(`ARF_OFS_LAST_TRAILER, last_tr, `ARF_RESP_OKAY);
      rd_chk(8'h10, 32'h0, `ARF_RESP_SLVERR);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(`ARF_OFS_STATUS, 32'h0, `ARF_RESP_OKAY);
      rd_chk(`ARF_OFS_CTX_CTL, 32'h0, `ARF_RESP_OKAY);
      conclude;
   end
endmodule
`default_nettype wire
